/* rtl/lar_map.vh */
`ifndef LAR_MAP_VH
`define LAR_MAP_VH
// Register byte offsets
`define LAR_CTRL        8'h00
`define LAR_LINK        8'h04
`define LAR_CMD         8'h08
`define LAR_STAT        8'h0c
`define LAR_IRQ_ST      8'h10
`define LAR_IRQ_MSK     8'h14
`define LAR_LIM_BASE    8'h20
// Control fields
`define LAR_CTRL_LATCH  2:0
`define LAR_CTRL_POL    5:3
`define LAR_CTRL_OR     8:6
`define LAR_CTRL_BAUD   10:9
`define LAR_CTRL_W      11
`define LAR_LINK_W      12
// Limit register fields
`define LAR_LIM_DLY     6:0
`define LAR_LIM_THR     14:8
`define LAR_NUM_LIM     6
// Limit ranges
`define LAR_DLY_MIN     7'd1
`define LAR_DLY_MAX     7'd99
`define LAR_THR_MIN     7'd10
`define LAR_THR_MAX     7'd100
// Reset values
`define LAR_DLY_RST     7'd1
`define LAR_THR_RST     7'd100
// Timing
`define LAR_CLK_HZ      200000000
`define LAR_CMP_MS      250
`define LAR_TICKS_PER_S 4
`define LAR_BAUD0       1200
`define LAR_BAUD1       2400
`define LAR_BAUD2       4800
`define LAR_BAUD3       9600
// Serial command that clears latched relays
`define LAR_CMD_RESET   8'h52
`endif

/* rtl/lar_delay.v */
`include "lar_map.vh"
module lar_delay (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       tick,
  input  wire       exc,
  input  wire [6:0] dly_s,
  output reg        qual_q
);
  reg  [8:0] cnt_q;
  wire [8:0] target = {2'b00, dly_s} * 9'd`LAR_TICKS_PER_S;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 9'h000;
      qual_q <= 1'b0;
    end else if (!exc) begin
      // Any gap restarts the wait
      cnt_q  <= 9'h000;
      qual_q <= 1'b0;
    end else if (tick && !qual_q) begin
      if (cnt_q + 9'h001 >= target) begin
        qual_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 9'h001;
      end
    end
  end
endmodule // lar_delay

/* rtl/lar_uart_rx.v */
module lar_uart_rx (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        rxd,
  input  wire [17:0] bit_cyc,
  output reg  [7:0]  data_q,
  output reg         vld_q
);
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STOP = 2'd3;

  reg [1:0]  s1_q;
  reg [1:0]  st_q;
  reg [17:0] cnt_q;
  reg [2:0]  bit_q;
  wire       rx = s1_q[1];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q   <= 2'b11;
      st_q   <= ST_IDLE;
      cnt_q  <= 18'h00000;
      bit_q  <= 3'd0;
      data_q <= 8'h00;
      vld_q  <= 1'b0;
    end else begin
      s1_q  <= {s1_q[0], rxd};
      vld_q <= 1'b0;
      if (cnt_q != 18'h00000) begin
        cnt_q <= cnt_q - 18'h00001;
      end else begin
        case (st_q)
          ST_IDLE: if (!rx) begin
            st_q  <= ST_START;
            cnt_q <= {1'b0, bit_cyc[17:1]};
          end
          ST_START: begin
            // Reload one short: the step at zero takes a cycle too
            st_q  <= rx ? ST_IDLE : ST_DATA;
            cnt_q <= bit_cyc - 18'h00001;
            bit_q <= 3'd0;
          end
          ST_DATA: begin
            // 8 data bits, LSB first, no parity
            data_q <= {rx, data_q[7:1]};
            cnt_q  <= bit_cyc - 18'h00001;
            bit_q  <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              st_q <= ST_STOP;
            end
          end
          default: begin
            // A bad stop bit drops the byte
            vld_q <= rx;
            st_q  <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // lar_uart_rx

/* rtl/lar_top.v */
// Notes on behaviour
// - Six limits, three per channel: first, second, bearing condition.
// - Thresholds clamp to 10..100 percent of channel range.
// - Each limit links to at most one relay.
// - A relay has zero to six linked limits.
// - AND mode trips only while all linked limits exceed.
// - OR mode trips while any linked limit exceeds.
// - Each alarm relay: normally energized or not, latching or not.
// - Per-limit alarm delay 1..99 seconds before exceedance counts.
// - Health relay normally energized, drops on self-monitor fault.
// - Contact reset input closure clears latched relays.
// - Panel or serial reset request also clears latched relays.
// - Two serial ports, data lines only, no handshake.
// - Serial frame 8N1, baud 1200, 2400, 4800 or 9600.
// - Separate latch and polarity setting per alarm relay.
// - Limits are compared every quarter second.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`include "lar_map.vh"
module lar_top #(
  parameter CLK_HZ  = `LAR_CLK_HZ,
  parameter QTR_CYC = `LAR_CLK_HZ / 1000 * `LAR_CMP_MS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [41:0] meas_pct,
  input  wire        fault_in,
  input  wire        contact_reset_n,
  input  wire        panel_reset,
  input  wire        rxd_a,
  output wire        txd_a,
  input  wire        rxd_b,
  output wire        txd_b,
  output reg         alarm_relay_one,
  output reg         alarm_relay_two,
  output reg         alarm_relay_three,
  output reg         health_relay,
  output wire        irq
);
  localparam N = `LAR_NUM_LIM;

  reg [`LAR_CTRL_W-1:0] ctrl_q;
  reg [`LAR_LINK_W-1:0] link_q;
  reg [6:0]  dly_q [0:N-1];
  reg [6:0]  thr_q [0:N-1];
  reg [4:0]  irq_st_q;
  reg [4:0]  irq_msk_q;
  reg        sw_reset_q;
  reg [N-1:0] exc_q;
  wire [N-1:0] qual;
  reg [2:0]  trip_q;
  reg [2:0]  trip_d;
  reg        fault_prev_q;
  reg [25:0] tick_cnt_q;
  reg        tick_q;
  reg [1:0]  fault_s_q;
  reg [1:0]  crst_s_q;
  reg [1:0]  prst_s_q;
  reg        aw_have_q;
  reg        w_have_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  integer    i;
  integer    j;
  integer    k;

  wire [2:0] relay_latch_cfg = ctrl_q[`LAR_CTRL_LATCH];
  wire [2:0] relay_pol_cfg   = ctrl_q[`LAR_CTRL_POL];
  wire [2:0] relay_or_cfg    = ctrl_q[`LAR_CTRL_OR];
  wire       relay_one_latch_cfg    = relay_latch_cfg[0];
  wire       relay_two_latch_cfg    = relay_latch_cfg[1];
  wire       relay_three_latch_cfg  = relay_latch_cfg[2];
  wire       relay_one_polarity_cfg   = relay_pol_cfg[0];
  wire       relay_two_polarity_cfg   = relay_pol_cfg[1];
  wire       relay_three_polarity_cfg = relay_pol_cfg[2];

  function [6:0] clamp;
    input [31:0] v;
    input [6:0]  lo;
    input [6:0]  hi;
    begin
      if (v < {25'h0, lo}) begin
        clamp = lo;
      end else if (v > {25'h0, hi}) begin
        clamp = hi;
      end else begin
        clamp = v[6:0];
      end
    end
  endfunction

  function [17:0] bit_cycles;
    input [1:0] sel;
    reg [31:0] c;
    begin
      case (sel)
        2'd0: c = CLK_HZ / `LAR_BAUD0;
        2'd1: c = CLK_HZ / `LAR_BAUD1;
        2'd2: c = CLK_HZ / `LAR_BAUD2;
        default: c = CLK_HZ / `LAR_BAUD3;
      endcase
      // Slowest rate at the top clock still fits 18 bits
      bit_cycles = c[17:0];
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[7:2] <= 6'h05) ||
               (a[7:5] == 3'b001 && a[4:2] < 3'd6);
    end
  endfunction

  function [31:0] rd_word;
    input [7:0] a;
    begin
      rd_word = 32'h00000000;
      if (a[7:2] == `LAR_CTRL >> 2) begin
        rd_word[`LAR_CTRL_W-1:0] = ctrl_q;
      end else if (a[7:2] == `LAR_LINK >> 2) begin
        rd_word[`LAR_LINK_W-1:0] = link_q;
      end else if (a[7:2] == `LAR_STAT >> 2) begin
        rd_word[16:0] = {health_relay, fault_s_q[1], qual, exc_q, trip_q};
      end else if (a[7:2] == `LAR_IRQ_ST >> 2) begin
        rd_word[4:0] = irq_st_q;
      end else if (a[7:2] == `LAR_IRQ_MSK >> 2) begin
        rd_word[4:0] = irq_msk_q;
      end else if (a[7:5] == 3'b001 && a[4:2] < 3'd6) begin
        rd_word[`LAR_LIM_DLY] = dly_q[a[4:2]];
        rd_word[`LAR_LIM_THR] = thr_q[a[4:2]];
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // Bus slave: address and data taken in either order
  wire        wr_en = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [31:0] wval = merge(rd_word(awaddr_q), wdata_q, wstrb_q);
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word(s_axi_araddr);
        s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pins from outside the clock domain
  always @(posedge aclk) begin
    if (!aresetn) begin
      fault_s_q <= 2'b00;
      crst_s_q  <= 2'b11;
      prst_s_q  <= 2'b00;
    end else begin
      fault_s_q <= {fault_s_q[0], fault_in};
      crst_s_q  <= {crst_s_q[0], contact_reset_n};
      prst_s_q  <= {prst_s_q[0], panel_reset};
    end
  end

  // Serial ports; transmit lines rest at idle mark
  wire [7:0] rx_a_data;
  wire [7:0] rx_b_data;
  wire       rx_a_vld;
  wire       rx_b_vld;
  wire [17:0] bit_cyc = bit_cycles(ctrl_q[`LAR_CTRL_BAUD]);
  assign txd_a = 1'b1;
  assign txd_b = 1'b1;

  lar_uart_rx u_rx_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rxd     (rxd_a),
    .bit_cyc (bit_cyc),
    .data_q  (rx_a_data),
    .vld_q   (rx_a_vld)
  );

  lar_uart_rx u_rx_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rxd     (rxd_b),
    .bit_cyc (bit_cyc),
    .data_q  (rx_b_data),
    .vld_q   (rx_b_vld)
  );

  wire ser_reset = (rx_a_vld && rx_a_data == `LAR_CMD_RESET) ||
                   (rx_b_vld && rx_b_data == `LAR_CMD_RESET);
  wire clr_latch = !crst_s_q[1] || prst_s_q[1] || sw_reset_q ||
                   ser_reset;

  // Configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= {`LAR_CTRL_W{1'b0}};
      link_q     <= {`LAR_LINK_W{1'b0}};
      irq_msk_q  <= 5'h00;
      sw_reset_q <= 1'b0;
      for (i = 0; i < N; i = i + 1) begin
        dly_q[i] <= `LAR_DLY_RST;
        thr_q[i] <= `LAR_THR_RST;
      end
    end else begin
      sw_reset_q <= 1'b0;
      if (wr_en) begin
        if (awaddr_q[7:2] == `LAR_CTRL >> 2) begin
          ctrl_q <= wval[`LAR_CTRL_W-1:0];
        end else if (awaddr_q[7:2] == `LAR_LINK >> 2) begin
          link_q <= wval[`LAR_LINK_W-1:0];
        end else if (awaddr_q[7:2] == `LAR_CMD >> 2) begin
          sw_reset_q <= wval[0];
        end else if (awaddr_q[7:2] == `LAR_IRQ_MSK >> 2) begin
          irq_msk_q <= wval[4:0];
        end else if (awaddr_q[7:5] == 3'b001 && awaddr_q[4:2] < 3'd6) begin
          dly_q[awaddr_q[4:2]] <= clamp({25'h0, wval[`LAR_LIM_DLY]},
            `LAR_DLY_MIN, `LAR_DLY_MAX);
          thr_q[awaddr_q[4:2]] <= clamp({25'h0, wval[`LAR_LIM_THR]},
            `LAR_THR_MIN, `LAR_THR_MAX);
        end
      end
    end
  end

  // Quarter-second compare strobe
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 26'h0000000;
      tick_q     <= 1'b0;
      exc_q      <= {N{1'b0}};
    end else begin
      tick_q <= 1'b0;
      if (tick_cnt_q >= QTR_CYC[25:0] - 26'h0000001) begin
        tick_cnt_q <= 26'h0000000;
        tick_q     <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 26'h0000001;
      end
      if (tick_q) begin
        for (k = 0; k < N; k = k + 1) begin
          exc_q[k] <= meas_pct[k*7 +: 7] >= thr_q[k];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_dly
      lar_delay u_dly (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick_q),
        .exc     (exc_q[g]),
        .dly_s   (dly_q[g]),
        .qual_q  (qual[g])
      );
    end
  endgenerate

  // A 2-bit relay code per limit keeps each limit on one relay
  reg [2:0] any_lnk;
  reg [2:0] all_exc;
  reg [2:0] any_exc;
  reg [2:0] cond;
  integer r;
  always @* begin
    for (r = 0; r < 3; r = r + 1) begin
      any_lnk[r] = 1'b0;
      all_exc[r] = 1'b1;
      any_exc[r] = 1'b0;
      for (j = 0; j < N; j = j + 1) begin
        if (link_q[j*2 +: 2] == r + 1) begin
          any_lnk[r] = 1'b1;
          all_exc[r] = all_exc[r] & qual[j];
          any_exc[r] = any_exc[r] | qual[j];
        end
      end
      // Relay with no limits never trips
      cond[r] = relay_or_cfg[r] ? any_exc[r] :
                (any_lnk[r] & all_exc[r]);
      // Live condition beats a reset
      trip_d[r] = cond[r] |
                  (relay_latch_cfg[r] & trip_q[r] & ~clr_latch);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      trip_q            <= 3'b000;
      fault_prev_q      <= 1'b0;
      irq_st_q          <= 5'h00;
      alarm_relay_one   <= 1'b0;
      alarm_relay_two   <= 1'b0;
      alarm_relay_three <= 1'b0;
      health_relay      <= 1'b0;
    end else begin
      trip_q       <= trip_d;
      fault_prev_q <= fault_s_q[1];
      // Energized when idle in normally energized mode
      alarm_relay_one   <= trip_q[0] ^ relay_one_polarity_cfg;
      alarm_relay_two   <= trip_q[1] ^ relay_two_polarity_cfg;
      alarm_relay_three <= trip_q[2] ^ relay_three_polarity_cfg;
      health_relay      <= !fault_s_q[1];
      // Set wins over write-one-to-clear
      irq_st_q <= (irq_st_q & ~(wr_en &&
                   awaddr_q[7:2] == `LAR_IRQ_ST >> 2 ? wval[4:0] : 5'h00))
                  | {clr_latch, fault_s_q[1] & ~fault_prev_q,
                     trip_d & ~trip_q};
    end
  end

  assign irq = |(irq_st_q & irq_msk_q);
endmodule // lar_top

/* dv/lar_top_chk.sv */
module lar_top_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        fault_in,
  input wire logic        health_relay,
  input wire logic        txd_a,
  input wire logic        txd_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  // Both flags settle one edge, the response follows one edge later
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no rvalid");
  // Sync chain plus register: three edges, four allowed
  a_fault_drop: assert property (fault_in [*4] |=> !health_relay)
    else $error("health relay held on fault");
  a_health_up: assert property (!fault_in [*6] |=> health_relay)
    else $error("health relay not energized");
  a_tx_idle: assert property (txd_a && txd_b)
    else $error("serial output left idle level");
endmodule // lar_top_chk

bind lar_top lar_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .fault_in, .health_relay, .txd_a, .txd_b);

/* dv/lar_far.sv */
module lar_far (
  input  wire logic aclk,
  input  wire logic txd_a,
  input  wire logic txd_b,
  output logic      rxd_a,
  output logic      rxd_b,
  output logic      contact_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Data lines only, idle at mark level
  initial begin
    rxd_a = 1'b1;
    rxd_b = 1'b1;
    contact_reset_n = 1'b1;
  end
  // Start, eight bits LSB first, one stop, no parity
  task automatic send(input bit port, input logic [7:0] b, input int cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      if (port) rxd_b <= f[i];
      else rxd_a <= f[i];
      repeat (cyc - 1) @(posedge aclk);
    end
  endtask
  // Switch closure, long enough to pass the synchroniser
  task automatic close(input int n);
    @(posedge aclk);
    contact_reset_n <= 1'b0;
    repeat (n) @(posedge aclk);
    contact_reset_n <= 1'b1;
  endtask
endmodule // lar_far

/* dv/lar_top_tb.sv */
module lar_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLK_HZ = 960000;
  localparam int QTR = 20;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0]  s_axi_wstrb = 0;
  logic [41:0] meas_pct = 0;
  logic        fault_in = 0, panel_reset = 0;
  logic [1:0]  rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, contact_reset_n, rxd_a, rxd_b, txd_a, txd_b;
  wire alarm_relay_one, alarm_relay_two, alarm_relay_three;
  wire health_relay, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0]  rly = {alarm_relay_three, alarm_relay_two, alarm_relay_one};
  int err_count = 0, tests_run = 0;

  always #2.5 aclk = ~aclk;

  lar_top #(.CLK_HZ(CLK_HZ), .QTR_CYC(QTR)) dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas_pct,
    .fault_in, .contact_reset_n, .panel_reset, .rxd_a, .txd_a, .rxd_b,
    .txd_b, .alarm_relay_one, .alarm_relay_two, .alarm_relay_three,
    .health_relay, .irq);
  lar_far far (.aclk, .txd_a, .txd_b, .rxd_a, .rxd_b, .contact_reset_n);

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string n);
    rdr(a);
    chk(n, e, rd);
  endtask
  task automatic meas(input int i, input logic [6:0] v);
    @(posedge aclk);
    meas_pct[7*i +: 7] <= v;
  endtask

  task automatic t_regs;
    rchk(8'h00, 32'h0, "ctrl reset");
    for (int i = 0; i < 6; i++) rchk(8'h20 + 4*i, 32'h6401, "lim reset");
    wr(8'h24, 32'h0500);
    chk("write resp", 32'h0, {30'h0, rs});
    rchk(8'h24, 32'h0a01, "lim low clamp");
    wr(8'h28, 32'h7f7f);
    rchk(8'h28, 32'h6463, "lim high clamp");
    rdr(8'h40);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    wr(8'h40, 32'h1);
    chk("unmapped wr resp", 32'h2, {30'h0, rs});
    for (int i = 0; i < 6; i++) wr(8'h20 + 4*i, 32'h3201);
    wr(8'h04, 32'h3a5);
    wr(8'h00, 32'h764);
    wr(8'h14, 32'h1);
    cyc(4);
    chk("idle relays", 3'b100, rly);
    chk("irq idle", 1'b0, irq);
  endtask
  task automatic t_or;
    meas(1, 7'd60);
    cyc(40);
    meas(1, 7'd0);
    cyc(30);
    meas(1, 7'd60);
    cyc(60);
    chk("gap restarts delay", 3'b100, rly);
    cyc(60);
    chk("or trip", 3'b101, rly);
    chk("irq raised", 1'b1, irq);
    wr(8'h10, 32'h1f);
    cyc(2);
    chk("irq cleared", 1'b0, irq);
    meas(1, 7'd0);
    cyc(50);
    chk("or release", 3'b100, rly);
  endtask
  task automatic t_and;
    meas(2, 7'd60);
    cyc(130);
    chk("and partial", 3'b100, rly);
    meas(3, 7'd50);
    cyc(130);
    chk("and trip", 3'b110, rly);
    meas(2, 7'd0);
    meas(3, 7'd0);
    cyc(50);
    chk("and release", 3'b100, rly);
  endtask
  // Latching relay, normally energized, so a trip drives it low
  task automatic t_latch;
    for (int s = 0; s < 5; s++) begin
      meas(4, 7'd100);
      cyc(130);
      chk("latch trip", 1'b0, rly[2]);
      meas(4, 7'd9);
      cyc(50);
      chk("latch hold", 1'b0, rly[2]);
      case (s)
        0: far.close(8);
        1: begin
          @(posedge aclk);
          panel_reset <= 1;
          cyc(6);
          panel_reset <= 0;
        end
        2: wr(8'h08, 32'h1);
        3: far.send(0, 8'h52, CLK_HZ / 9600);
        default: begin
          wr(8'h00, 32'h164);
          far.send(1, 8'h52, CLK_HZ / 1200);
        end
      endcase
      cyc(12);
      chk("latch cleared", 1'b1, rly[2]);
    end
  endtask
  task automatic t_fault;
    chk("health ok", 1'b1, health_relay);
    @(posedge aclk);
    fault_in <= 1;
    cyc(6);
    chk("health drop", 1'b0, health_relay);
    fault_in <= 0;
    cyc(6);
    chk("health back", 1'b1, health_relay);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Slowest frame is about 8000 cycles; whole run well under this
  initial begin
    cyc(80000);
    err_count++;
    final_report;
  end
  initial begin
    cyc(6);
    aresetn <= 1;
    cyc(4);
    t_regs;
    t_or;
    t_and;
    t_latch;
    t_fault;
    final_report;
  end
endmodule // lar_top_tb
